// ---- hw/imo_pkg.sv ----
// Purpose: Shared types and constants for the overhead cell and link control block.
// Assumes: One 125 MHz core clock, one byte per clock on both cell streams.
// Notes: Octet numbers count from 1, as on the line.
package imo_pkg;
	localparam int NUM_LINKS = 32;
	typedef enum logic [2:0] {NOT_IN_GROUP, UNUSABLE, USABLE, ACTIVE} link_state_t;
	localparam logic [1:0] DEF_NONE = 2'h0;
	localparam logic [1:0] DEF_PHY = 2'h1;
	localparam logic [1:0] DEF_LOSS_OF_GROUP_FRAME = 2'h2;
	localparam logic [1:0] DEF_LINK_OUT_OF_DELAY_SYNC = 2'h3;
	// -------------------------------------------------------------
	// Cell layout
	// -------------------------------------------------------------
	localparam logic [5:0] O_FILL_H4 = 6'h04;
	localparam logic [5:0] O_FILL_HEC = 6'h05;
	localparam logic [5:0] O_LABEL = 6'h06;
	localparam logic [5:0] O_CID = 6'h07;
	localparam logic [5:0] O_CCI = 6'h0b;
	localparam logic [5:0] O_HEAD_END = 6'h0e;
	localparam logic [5:0] O_TEST = 6'h0f;
	localparam logic [5:0] O_TXPAT = 6'h10;
	localparam logic [5:0] O_RXPAT = 6'h11;
	localparam logic [5:0] O_LINK0 = 6'h12;
	localparam logic [5:0] O_LINKN = 6'h31;
	localparam logic [5:0] O_E2E = 6'h33;
	localparam logic [5:0] O_CRC_HI = 6'h34;
	localparam logic [5:0] O_CRC_LO = 6'h35;
	localparam logic [7:0] PAD_BYTE = 8'h6a;
	localparam logic [7:0] FILL_H4 = 8'h0b;
	localparam logic [7:0] FILL_HEC = 8'h64;
	localparam logic [7:0] VER_10 = 8'h01;
	localparam logic [7:0] VER_11 = 8'h03;
	localparam logic [9:0] CRC_POLY = 10'h233;
	// One stuffed control cell after every 2048 cells.
	localparam logic [11:0] STUFF_PERIOD = 12'h800;
	// -------------------------------------------------------------
	// Delay buffer sizing
	// -------------------------------------------------------------
	localparam logic [31:0] BUF_UNIT_BYTES = 32'h0000_2000;
	localparam logic [31:0] INT_BUF_BYTES = 32'h0004_0000;
	localparam logic [31:0] EXT_BUF_BYTES = 32'h0020_0000;
	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TEST = 8'h04;
	localparam logic [7:0] REG_FDIV = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int CTRL_INDEP = 0;
	localparam int CTRL_FSRC = 1;
	localparam int CTRL_EXT = 2;
	localparam int CTRL_V11 = 3;
	localparam int CTRL_REF_LINK = 4;
	localparam int CTRL_PORTS = 16;
	localparam int CTRL_UNITS = 24;
	localparam int TEST_CMD = 5;
	localparam int TEST_PAT = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_t;
	typedef struct packed {
		logic valid;
		logic sof;
		logic [7:0] data;
	} byte_stream_t;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] test;
		logic [15:0] fdiv;
		logic [31:0] rdata;
		logic tx_busy;
		logic tx_filler;
		logic [5:0] tx_idx;
		logic [9:0] tx_crc;
		byte_stream_t tx_out;
		logic [7:0] cci;
		logic [303:0] snap;
		logic [5:0] rx_idx;
		logic rx_filler;
		logic [9:0] rx_crc;
		logic [1:0] rx_low;
		logic [7:0] rx_errs;
		logic rx_good;
		logic rx_bad;
		logic [7:0] rx_pat_sh;
		logic [7:0] rx_pat;
		logic [31:0][7:0] far_sh;
		logic [31:0][7:0] far;
		link_state_t [31:0] tx_st;
		link_state_t [31:0] rx_st;
		logic [11:0] stuff_cnt;
		logic [31:0] stuff_due;
		logic [15:0] frame_cnt;
		logic frame_tick;
		logic int_buf_en;
		logic delay_fit;
	} state_t;
	function automatic logic [9:0] crc_bits(input logic [9:0] c, input logic [7:0] d, input int n);
		logic [9:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (i < n) begin
				fb = r[9] ^ d[7 - i];
				r = {r[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
			end
		end
		return r;
	endfunction
endpackage

// ---- hw/ima_overhead_cell_and_link_control.sv ----
// Purpose: Builds and checks overhead cells and runs the per-link state machines.
// Assumes: Cell bytes move one per clock; octets 1 to 14 of a control cell except octets 6 and 11 come from outside.
// Notes: The delay buffer memory itself lives elsewhere; this block sizes and enables it.
//
// Summary of operation
// - Octet 15: bits 7-6 zero, bit 5 test command, bits 4-0 test link id.
// - Octet 18: link 0 transmit state, receive state, defect code.
// - Defect code: none, physical defect, lost group frame, out of delay sync.
// - Octets 19 to 49 hold links 1 to 31 in the same layout.
// - Control octet 50 and filler octets 8 to 51 carry 0x6a.
// - Control octet 51 is sent as zero and ignored on receive.
// - Octets 52-53: six zero bits then a 10-bit check over octets 6 to 51 and those six bits.
// - Filler header is three zero octets, then 0x0b, then 0x64.
// - Octet 6 gives the version: 0x01 for 1.0, 0x03 for 1.1.
// - Filler octet 7 is all zero.
// - Each link is out of group, unusable, usable or active.
// - Transmit and receive state machines per link run entirely in hardware.
// - Common clock mode: all links stuff together at the reference link rate.
// - Independent mode: non-reference links stuff at their own request.
// - Group frame rate comes from reference clock ticks or reference cell rate.
// - Buffering must absorb at least 25 ms of differential delay.
// - Eight kilobytes per port per 27.5 ms delay unit, scaled linearly.
// - 256K internal buffer, 2 MB external; internal disabled when external used.
// - Change count steps modulo 256 whenever octets 12 to 49 change.
module ima_overhead_cell_and_link_control (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register port.
	input wire imo_pkg::bus_req_t bus,
	output logic [31:0] rdata,
	// Transmit cell stream.
	input wire logic tx_start,
	input wire logic tx_filler,
	input wire logic [13:0][7:0] ctrl_head,
	output imo_pkg::byte_stream_t tx_out,
	// Receive cell stream.
	input wire imo_pkg::byte_stream_t rx_in,
	output logic rx_good,
	output logic rx_bad,
	// Links.
	input wire logic [imo_pkg::NUM_LINKS-1:0] link_add,
	input wire logic [imo_pkg::NUM_LINKS-1:0][1:0] link_defect,
	input wire logic [imo_pkg::NUM_LINKS-1:0] link_stuff_req,
	output imo_pkg::link_state_t [imo_pkg::NUM_LINKS-1:0] tx_link_state,
	output imo_pkg::link_state_t [imo_pkg::NUM_LINKS-1:0] rx_link_state,
	output logic [imo_pkg::NUM_LINKS-1:0] stuff_due,
	// Timing reference and buffer.
	input wire logic cell_tick,
	input wire logic rec_clk_tick,
	output logic frame_tick,
	output logic int_buf_en
);
	imo_pkg::state_t s;
	imo_pkg::state_t next_s;
	wire [31:0][7:0] link_oct;
	wire [2:0] next_tx_st [imo_pkg::NUM_LINKS];
	wire [2:0] next_rx_st [imo_pkg::NUM_LINKS];
	wire [imo_pkg::NUM_LINKS-1:0] next_stuff;
	wire [303:0] cur;
	wire indep;
	wire fsrc;
	wire ext;
	wire [4:0] ref_link;
	wire [5:0] ports;
	wire [3:0] units;
	wire [7:0] ver;
	wire stuff_ev;
	wire frame_src;

	// -------------------------------------------------------------
	// Configuration fields
	// -------------------------------------------------------------
	assign indep = s.ctrl[imo_pkg::CTRL_INDEP];
	assign fsrc = s.ctrl[imo_pkg::CTRL_FSRC];
	assign ext = s.ctrl[imo_pkg::CTRL_EXT];
	assign ref_link = s.ctrl[imo_pkg::CTRL_REF_LINK +: 5];
	assign ports = s.ctrl[imo_pkg::CTRL_PORTS +: 6];
	assign units = s.ctrl[imo_pkg::CTRL_UNITS +: 4];
	assign ver = s.ctrl[imo_pkg::CTRL_V11] ? imo_pkg::VER_11 : imo_pkg::VER_10;
	assign stuff_ev = cell_tick && (s.stuff_cnt == imo_pkg::STUFF_PERIOD);
	assign frame_src = fsrc ? cell_tick : rec_clk_tick;
	// Octets 12 to 49 as they would be sent now.
	assign cur = {ctrl_head[13:11], 2'h0, s.test[5:0], s.test[15:8], s.rx_pat, link_oct};

	// -------------------------------------------------------------
	// Per-link state machines
	// -------------------------------------------------------------
	// A link only goes active after a cycle as usable, so a link leaving a fault always passes usable.
	for (genvar i = 0; i < imo_pkg::NUM_LINKS; i++) begin : g_link
		assign link_oct[i] = {s.tx_st[i], s.rx_st[i], link_defect[i]};
		assign next_tx_st[i] = !link_add[i] ? imo_pkg::NOT_IN_GROUP :
			(link_defect[i] != imo_pkg::DEF_NONE) ? imo_pkg::UNUSABLE :
			((s.tx_st[i] == imo_pkg::USABLE || s.tx_st[i] == imo_pkg::ACTIVE) &&
			(s.far[i][4:2] == 3'(imo_pkg::USABLE) || s.far[i][4:2] == 3'(imo_pkg::ACTIVE)))
			? imo_pkg::ACTIVE : imo_pkg::USABLE;
		assign next_rx_st[i] = !link_add[i] ? imo_pkg::NOT_IN_GROUP :
			(link_defect[i] != imo_pkg::DEF_NONE) ? imo_pkg::UNUSABLE :
			((s.rx_st[i] == imo_pkg::USABLE || s.rx_st[i] == imo_pkg::ACTIVE) &&
			s.far[i][7:5] == 3'(imo_pkg::ACTIVE)) ? imo_pkg::ACTIVE : imo_pkg::USABLE;
		assign next_stuff[i] = (!indep || 5'(i) == ref_link) ? stuff_ev : link_stuff_req[i];
	end

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		logic [7:0] b;
		logic [5:0] ri;
		logic [9:0] c6;
		logic [31:0] req;
		b = imo_pkg::PAD_BYTE;
		ri = 6'h00;
		c6 = imo_pkg::crc_bits(s.tx_crc, 8'h00, 6);
		req = 32'(ports) * 32'(units) * imo_pkg::BUF_UNIT_BYTES;
		next_s = s;
		next_s.rx_good = 1'b0;
		next_s.rx_bad = 1'b0;
		next_s.frame_tick = 1'b0;
		next_s.tx_out = '0;
		next_s.rdata = 32'h0000_0000;
		if (bus.wr) begin
			case (bus.addr)
				imo_pkg::REG_CTRL: next_s.ctrl = bus.wdata;
				imo_pkg::REG_TEST: next_s.test = bus.wdata[15:0];
				imo_pkg::REG_FDIV: next_s.fdiv = bus.wdata[15:0];
				default: ;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				imo_pkg::REG_CTRL: next_s.rdata = s.ctrl;
				imo_pkg::REG_TEST: next_s.rdata = {16'h0000, s.test};
				imo_pkg::REG_FDIV: next_s.rdata = {16'h0000, s.fdiv};
				imo_pkg::REG_STATUS: next_s.rdata = {6'h00, s.int_buf_en, s.delay_fit,
					s.rx_pat, s.rx_errs, s.cci};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
		// Transmit cell builder.
		if (s.tx_busy) begin
			if (s.tx_filler) begin
				if (s.tx_idx < imo_pkg::O_FILL_H4) begin
					b = 8'h00;
				end else if (s.tx_idx == imo_pkg::O_FILL_H4) begin
					b = imo_pkg::FILL_H4;
				end else if (s.tx_idx == imo_pkg::O_FILL_HEC) begin
					b = imo_pkg::FILL_HEC;
				end else if (s.tx_idx == imo_pkg::O_LABEL) begin
					b = ver;
				end else if (s.tx_idx == imo_pkg::O_CID) begin
					b = 8'h00;
				end
			end else begin
				if (s.tx_idx == imo_pkg::O_LABEL) begin
					b = ver;
				end else if (s.tx_idx == imo_pkg::O_CCI) begin
					b = s.cci;
				end else if (s.tx_idx <= imo_pkg::O_HEAD_END) begin
					b = ctrl_head[s.tx_idx - 6'h01];
				end else if (s.tx_idx == imo_pkg::O_TEST) begin
					b = {2'h0, s.test[imo_pkg::TEST_CMD], s.test[4:0]};
				end else if (s.tx_idx == imo_pkg::O_TXPAT) begin
					b = s.test[imo_pkg::TEST_PAT +: 8];
				end else if (s.tx_idx == imo_pkg::O_RXPAT) begin
					b = s.rx_pat;
				end else if (s.tx_idx <= imo_pkg::O_LINKN) begin
					b = link_oct[5'(s.tx_idx - imo_pkg::O_LINK0)];
				end else if (s.tx_idx == imo_pkg::O_E2E) begin
					b = 8'h00;
				end
			end
			if (s.tx_idx == imo_pkg::O_CRC_HI) begin
				b = {6'h00, c6[9:8]};
				next_s.tx_crc = c6;
			end else if (s.tx_idx == imo_pkg::O_CRC_LO) begin
				b = s.tx_crc[7:0];
				next_s.tx_busy = 1'b0;
			end else if (s.tx_idx >= imo_pkg::O_LABEL) begin
				next_s.tx_crc = imo_pkg::crc_bits(s.tx_crc, b, 8);
			end
			next_s.tx_out.valid = 1'b1;
			next_s.tx_out.sof = (s.tx_idx == 6'h01);
			next_s.tx_out.data = b;
			next_s.tx_idx = s.tx_idx + 6'h01;
		end else if (tx_start) begin
			next_s.tx_busy = 1'b1;
			next_s.tx_filler = tx_filler;
			next_s.tx_idx = 6'h01;
			next_s.tx_crc = 10'h000;
			if (!tx_filler && cur != s.snap) begin
				next_s.cci = s.cci + 8'h01;
				next_s.snap = cur;
			end
		end
		// Receive cell checker.
		if (rx_in.valid) begin
			ri = rx_in.sof ? 6'h01 : (s.rx_idx == 6'h00 ? 6'h00 : s.rx_idx + 6'h01);
			next_s.rx_idx = ri;
			if (ri == 6'h01) begin
				next_s.rx_crc = 10'h000;
			end
			if (ri >= imo_pkg::O_LABEL && ri <= imo_pkg::O_E2E) begin
				next_s.rx_crc = imo_pkg::crc_bits(s.rx_crc, rx_in.data, 8);
			end
			if (ri == imo_pkg::O_CID) begin
				next_s.rx_filler = !rx_in.data[7];
			end
			if (ri == imo_pkg::O_TXPAT) begin
				next_s.rx_pat_sh = rx_in.data;
			end
			if (ri >= imo_pkg::O_LINK0 && ri <= imo_pkg::O_LINKN) begin
				next_s.far_sh[5'(ri - imo_pkg::O_LINK0)] = rx_in.data;
			end
			if (ri == imo_pkg::O_CRC_HI) begin
				next_s.rx_crc = imo_pkg::crc_bits(s.rx_crc, rx_in.data, 6);
				next_s.rx_low = rx_in.data[1:0];
			end
			if (ri == imo_pkg::O_CRC_LO) begin
				next_s.rx_idx = 6'h00;
				if ({s.rx_low, rx_in.data} == s.rx_crc) begin
					next_s.rx_good = 1'b1;
					if (!s.rx_filler) begin
						next_s.far = s.far_sh;
						next_s.rx_pat = s.rx_pat_sh;
					end
				end else begin
					next_s.rx_bad = 1'b1;
					next_s.rx_errs = s.rx_errs + 8'h01;
				end
			end
		end
		// Link states, stuffing and frame rate.
		for (int i = 0; i < imo_pkg::NUM_LINKS; i++) begin
			next_s.tx_st[i] = imo_pkg::link_state_t'(next_tx_st[i]);
			next_s.rx_st[i] = imo_pkg::link_state_t'(next_rx_st[i]);
		end
		next_s.stuff_due = next_stuff;
		if (cell_tick) begin
			next_s.stuff_cnt = stuff_ev ? 12'h000 : s.stuff_cnt + 12'h001;
		end
		if (frame_src) begin
			if (s.frame_cnt + 16'h0001 >= s.fdiv) begin
				next_s.frame_cnt = 16'h0000;
				next_s.frame_tick = 1'b1;
			end else begin
				next_s.frame_cnt = s.frame_cnt + 16'h0001;
			end
		end
		// Only the buffer in use is enabled; both at once would split the realignment memory.
		next_s.int_buf_en = !ext;
		next_s.delay_fit = req <= (ext ? imo_pkg::EXT_BUF_BYTES : imo_pkg::INT_BUF_BYTES);
	end

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.ctrl <= imo_pkg::CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign tx_out = s.tx_out;
	assign rx_good = s.rx_good;
	assign rx_bad = s.rx_bad;
	assign tx_link_state = s.tx_st;
	assign rx_link_state = s.rx_st;
	assign stuff_due = s.stuff_due;
	assign frame_tick = s.frame_tick;
	assign int_buf_en = s.int_buf_en;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_test_octet;
		s.tx_busy && !s.tx_filler && s.tx_idx == imo_pkg::O_TEST
		|=> tx_out.data == {2'h0, $past(s.test[5:0])};
	endproperty
	a_test_octet: assert property (p_test_octet)
		else $error("test control octet wrong");

	property p_link0_octet;
		s.tx_busy && !s.tx_filler && s.tx_idx == imo_pkg::O_LINK0
		|=> tx_out.data[7:5] == 3'($past(s.tx_st[0])) && tx_out.data[1:0] == $past(link_defect[0]);
	endproperty
	a_link0_octet: assert property (p_link0_octet)
		else $error("link 0 octet wrong");

	property p_filler_pad;
		s.tx_busy && s.tx_filler && s.tx_idx > imo_pkg::O_CID && s.tx_idx <= imo_pkg::O_E2E
		|=> tx_out.valid && tx_out.data == imo_pkg::PAD_BYTE;
	endproperty
	a_filler_pad: assert property (p_filler_pad)
		else $error("filler pad octet wrong");

	property p_e2e_zero;
		s.tx_busy && !s.tx_filler && s.tx_idx == imo_pkg::O_E2E
		|=> tx_out.data == 8'h00 ##1 tx_out.data[7:2] == 6'h00;
	endproperty
	a_e2e_zero: assert property (p_e2e_zero)
		else $error("octet 51 or reserved check bits not zero");

	property p_filler_head;
		s.tx_busy && s.tx_filler && s.tx_idx == 6'h01
		|=> tx_out.sof && tx_out.data == 8'h00 ##3 tx_out.data == imo_pkg::FILL_H4
		##1 tx_out.data == imo_pkg::FILL_HEC ##1 tx_out.data == $past(ver, 6) ##1 tx_out.data == 8'h00;
	endproperty
	a_filler_head: assert property (p_filler_head)
		else $error("filler header wrong");

	property p_link_leave;
		!link_add[0] |=> s.tx_st[0] == imo_pkg::NOT_IN_GROUP && s.rx_st[0] == imo_pkg::NOT_IN_GROUP;
	endproperty
	a_link_leave: assert property (p_link_leave)
		else $error("removed link not out of group");

	property p_defect_unusable;
		link_add[1] && link_defect[1] != imo_pkg::DEF_NONE
		|=> s.rx_st[1] == imo_pkg::UNUSABLE && s.tx_st[1] == imo_pkg::UNUSABLE;
	endproperty
	a_defect_unusable: assert property (p_defect_unusable)
		else $error("faulty link not unusable");

	property p_common_stuff;
		!indep && cell_tick && s.stuff_cnt == imo_pkg::STUFF_PERIOD
		|=> stuff_due == '1 ##1 stuff_due == '0;
	endproperty
	a_common_stuff: assert property (p_common_stuff)
		else $error("common mode stuff not on all links");

	property p_indep_stuff;
		indep && ref_link != 5'h02 |=> stuff_due[2] == $past(link_stuff_req[2]);
	endproperty
	a_indep_stuff: assert property (p_indep_stuff)
		else $error("independent stuff request not followed");

	property p_internal_fit;
		!ext && ports <= 6'h20 && units == 4'h1 && $stable(s.ctrl) |=> s.delay_fit && int_buf_en;
	endproperty
	a_internal_fit: assert property (p_internal_fit)
		else $error("internal buffer does not hold one delay unit");

	property p_change_count;
		!s.tx_busy && tx_start && !tx_filler && cur != s.snap |=> s.cci == $past(s.cci) + 8'h01;
	endproperty
	a_change_count: assert property (p_change_count)
		else $error("change count did not step");

	property p_bad_dropped;
		rx_bad |-> s.far == $past(s.far) && s.rx_errs == $past(s.rx_errs) + 8'h01;
	endproperty
	a_bad_dropped: assert property (p_bad_dropped)
		else $error("bad cell not dropped");

	c_filler_sent: cover property (s.tx_busy && s.tx_filler && s.tx_idx == imo_pkg::O_CRC_LO);
	c_ctrl_good: cover property (rx_good && !s.rx_filler);
	c_stuff: cover property (stuff_due[0]);
	c_frame: cover property (frame_tick ##[1:20] frame_tick);
endmodule // ima_overhead_cell_and_link_control

// ---- tb/peer_ima_model.sv ----
// Purpose: Far-end peer that sends overhead cells and captures the cells we send.
// Assumes: One byte per clock, sof on octet 1.
// Notes: Idle data shows the inverse of the last byte so a stale value never passes.
module peer_ima_model (
	// Clock.
	input wire logic clk,
	// Cell streams.
	input wire imo_pkg::byte_stream_t tx_out,
	output imo_pkg::byte_stream_t rx_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [1:53];
	int pos = 0;
	// -------------------------------------------------------------
	// Capture and send
	// -------------------------------------------------------------
	initial rx_in = '0;
	// Sampled on the falling edge so the capture never races the registered stream.
	always @(negedge clk) begin
		if (tx_out.valid === 1'b1) begin
			pos = (tx_out.sof === 1'b1) ? 1 : pos + 1;
			if (pos <= 53) got[pos] = tx_out.data;
		end
	end
	function automatic logic [9:0] crc10(input logic [7:0] c [1:53]);
		logic [9:0] r;
		logic fb;
		r = 10'h000;
		for (int n = 0; n < 374; n++) begin
			fb = r[9] ^ (n < 368 && c[6 + n / 8][7 - n % 8]);
			r = {r[8:0], 1'b0} ^ (fb ? imo_pkg::CRC_POLY : 10'h000);
		end
		return r;
	endfunction
	task automatic send(input logic [7:0] c [1:53], input logic bad);
		logic [7:0] b [1:53];
		logic [9:0] r;
		b = c;
		r = crc10(c);
		b[52] = {6'h00, r[9:8]};
		b[53] = r[7:0] ^ {7'h00, bad};
		for (int k = 1; k <= 53; k++) begin
			@(posedge clk);
			rx_in <= '{1'b1, k == 1, b[k]};
		end
		@(posedge clk);
		rx_in <= '{1'b0, 1'b0, ~b[53]};
	endtask
endmodule // peer_ima_model

// ---- tb/tb_ima_overhead_cell_and_link_control.sv ----
// Purpose: Self-checking bench for the overhead cell and link control block.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Each bus task leaves one idle cycle so no strobe is driven twice in a step.
module tb_ima_overhead_cell_and_link_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	imo_pkg::bus_req_t bus = '0;
	logic [31:0] rdata, stuff_due, v, c1;
	logic tx_start = 1'b0, tx_filler = 1'b0, cell_tick = 1'b0, rec_clk_tick = 1'b0;
	logic [13:0][7:0] ctrl_head = '0;
	imo_pkg::byte_stream_t tx_out, rx_in;
	logic rx_good, rx_bad, frame_tick, int_buf_en;
	logic [31:0] link_add = '0, link_stuff_req = '0;
	logic [31:0][1:0] link_defect = '0;
	imo_pkg::link_state_t [31:0] tx_link_state, rx_link_state;
	int err_total = 0, num_checks = 0, n_good = 0, n_bad = 0, n_frame = 0, n_s0 = 0, n_s3 = 0;
	logic [31:0] bt [4] = '{32'h0120_0000, 32'h0220_0000, 32'h0820_0004, 32'h0821_0004};
	ima_overhead_cell_and_link_control i_ima_overhead_cell_and_link_control (.clk(clk),
		.rst_n(rst_n), .bus(bus), .rdata(rdata), .tx_start(tx_start), .tx_filler(tx_filler),
		.ctrl_head(ctrl_head), .tx_out(tx_out), .rx_in(rx_in), .rx_good(rx_good),
		.rx_bad(rx_bad), .link_add(link_add), .link_defect(link_defect),
		.link_stuff_req(link_stuff_req), .tx_link_state(tx_link_state),
		.rx_link_state(rx_link_state), .stuff_due(stuff_due), .cell_tick(cell_tick),
		.rec_clk_tick(rec_clk_tick), .frame_tick(frame_tick), .int_buf_en(int_buf_en));
	peer_ima_model i_peer_ima_model (.clk(clk), .tx_out(tx_out), .rx_in(rx_in));
	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	always #4 clk = ~clk;
	always @(negedge clk) begin
		if (rx_good === 1'b1) n_good++;
		if (rx_bad === 1'b1) n_bad++;
		if (frame_tick === 1'b1) n_frame++;
		if (stuff_due[0] === 1'b1) n_s0++;
		if (stuff_due[3] === 1'b1) n_s3++;
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic txc(input logic f);
		tx_filler <= f;
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		repeat (58) @(posedge clk);
	endtask
	task automatic cmp_cell(input logic [7:0] e [1:53]);
		logic [9:0] r;
		r = i_peer_ima_model.crc10(e);
		e[52] = {6'h00, r[9:8]};
		e[53] = r[7:0];
		for (int k = 1; k <= 53; k++) begin
			chk($sformatf("octet %0d", k), {24'h0, e[k]}, {24'h0, i_peer_ima_model.got[k]});
		end
	endtask
	function automatic logic [2:0] lst(input int k, input logic act);
		if (!link_add[k]) return 3'h0;
		if (link_defect[k] != 2'h0) return 3'h1;
		return (act && k == 2) ? 3'h3 : 3'h2;
	endfunction
	task automatic chk_states(input logic act);
		for (int k = 0; k < 32; k++) begin
			chk("tx state", {29'h0, lst(k, act)}, {29'h0, tx_link_state[k]});
			chk("rx state", {29'h0, lst(k, act)}, {29'h0, rx_link_state[k]});
		end
	endtask
	task automatic chk_fill(input logic [7:0] ver);
		logic [7:0] e [1:53];
		for (int k = 1; k <= 53; k++) e[k] = (k > 7) ? imo_pkg::PAD_BYTE : 8'h00;
		e[4] = imo_pkg::FILL_H4;
		e[5] = imo_pkg::FILL_HEC;
		e[6] = ver;
		cmp_cell(e);
	endtask
	task automatic chk_ctrl(input logic [15:0] t, input logic [7:0] rp);
		logic [7:0] e [1:53];
		rd(imo_pkg::REG_STATUS, v);
		for (int k = 1; k <= 14; k++) e[k] = ctrl_head[k - 1];
		e[6] = imo_pkg::VER_10;
		e[11] = v[7:0];
		e[15] = {2'b00, t[5:0]};
		e[16] = t[15:8];
		e[17] = rp;
		for (int k = 0; k < 32; k++) e[18 + k] = {lst(k, 1), lst(k, 1), link_defect[k]};
		e[50] = imo_pkg::PAD_BYTE;
		e[51] = 8'h00;
		cmp_cell(e);
	endtask
	task automatic peer_cell(input logic [7:0] pat, input logic bad, input logic fill);
		logic [7:0] c [1:53];
		for (int k = 1; k <= 53; k++) c[k] = (fill && k > 7) ? imo_pkg::PAD_BYTE : 8'h00;
		c[4] = imo_pkg::FILL_H4;
		c[5] = imo_pkg::FILL_HEC;
		c[6] = imo_pkg::VER_10;
		if (!fill) begin
			c[7] = 8'h80;
			c[16] = pat;
			c[20] = 8'h68;
			c[50] = imo_pkg::PAD_BYTE;
			c[51] = 8'hff;
		end
		i_peer_ima_model.send(c, bad);
		repeat (4) @(posedge clk);
	endtask
	task automatic ticks(input int n, input logic rec);
		repeat (n) begin
			{rec_clk_tick, cell_tick} <= {rec, !rec};
			@(posedge clk);
			{rec_clk_tick, cell_tick} <= 2'b00;
			@(posedge clk);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// -------------------------------------------------------------
	// Tests
	// -------------------------------------------------------------
	initial begin
		#300us;
		err_total++;
		test_done();
	end
	initial begin
		for (int k = 0; k < 14; k++) ctrl_head[k] = 8'h80 + 8'(k);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(imo_pkg::REG_CTRL, v);
		chk("ctrl reset", imo_pkg::CTRL_RST, v);
		chk("int buf", 32'h1, {31'h0, int_buf_en});
		wr(8'h10, 32'hffff_ffff);
		rd(8'h10, v);
		chk("unmapped", 32'h0, v);
		#1 chk("rdata idle", 32'h0, rdata);
		@(posedge clk);
		link_add <= 32'h0000_007e;
		link_defect <= 64'h3904;
		repeat (3) @(posedge clk);
		chk_states(1'b0);
		txc(1'b1);
		chk_fill(imo_pkg::VER_10);
		wr(imo_pkg::REG_CTRL, 32'h0000_0008);
		txc(1'b1);
		chk_fill(imo_pkg::VER_11);
		wr(imo_pkg::REG_CTRL, 32'h0000_0000);
		peer_cell(8'h3c, 1'b0, 1'b0);
		chk_states(1'b1);
		peer_cell(8'h99, 1'b1, 1'b0);
		peer_cell(8'h77, 1'b0, 1'b1);
		chk_states(1'b1);
		rd(imo_pkg::REG_STATUS, v);
		chk("rx pattern and errors", 32'h3c01, v[23:8]);
		chk("good and bad", 32'h21, {n_good[27:0], n_bad[3:0]});
		wr(imo_pkg::REG_TEST, 32'h0000_a525);
		txc(1'b0);
		chk_ctrl(16'ha525, 8'h3c);
		c1 = v;
		chk("count first", 32'h1, {24'h0, c1[7:0]});
		txc(1'b0);
		chk_ctrl(16'ha525, 8'h3c);
		chk("count steady", {24'h0, c1[7:0]}, {24'h0, v[7:0]});
		wr(imo_pkg::REG_TEST, 32'h0000_5a25);
		txc(1'b0);
		chk_ctrl(16'h5a25, 8'h3c);
		chk("count step", {24'h0, c1[7:0] + 8'h01}, {24'h0, v[7:0]});
		wr(imo_pkg::REG_FDIV, 32'h0000_0003);
		ticks(9, 1'b1);
		chk("frames rec", 32'd3, n_frame);
		wr(imo_pkg::REG_CTRL, 32'h0000_0002);
		ticks(4098, 1'b0);
		chk("frames cell", 32'd1369, n_frame);
		chk("stuff common", 32'h22, {n_s0[27:0], n_s3[3:0]});
		wr(imo_pkg::REG_CTRL, 32'h0000_0001);
		link_stuff_req <= 32'h0000_000d;
		@(posedge clk);
		link_stuff_req <= 32'h0;
		repeat (3) @(posedge clk);
		chk("stuff indep", 32'h23, {n_s0[27:0], n_s3[3:0]});
		for (int i = 0; i < 4; i++) begin
			wr(imo_pkg::REG_CTRL, bt[i]);
			rd(imo_pkg::REG_STATUS, v);
			chk("buffer fit", 32'(3 - i), {30'h0, v[25:24]});
			chk("int buf pin", {31'h0, !bt[i][imo_pkg::CTRL_EXT]}, {31'h0, int_buf_en});
		end
		test_done();
	end
endmodule // tb_ima_overhead_cell_and_link_control
